// file: rtl/pcg_pkg.sv
package pcg_pkg;
   // ==========================================
   // Bus and register map (indexes; byte address = index * 4)
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 16;
   localparam logic [ADDR_W-1:0] IDX_GATE_TWO = 16'h1c03;
   localparam logic [ADDR_W-1:0] IDX_GATE_ONE = 16'h1c10;
   localparam logic [ADDR_W-1:0] IDX_STOP_HS = 16'h1c3a;
   localparam int unsigned BYTE_SHIFT = 2;

   // ==========================================
   // Gate register one fields
   localparam int unsigned G1_AUDIO3 = 0;
   localparam int unsigned G1_SYNC_SER = 1;
   localparam int unsigned G1_ASYNC_SER = 2;
   localparam int unsigned G1_XFER0 = 3;
   localparam int unsigned G1_CARD0 = 4;
   localparam logic [REG_W-1:0] G1_RESET = 16'h0000;

   // ==========================================
   // Gate register two fields
   localparam int unsigned G2_HOST_LINK = 2;
   localparam int unsigned G2_XFER1 = 3;
   localparam int unsigned G2_XFER2 = 4;
   localparam int unsigned G2_XFER3 = 5;
   localparam int unsigned G2_ANALOG = 6;
   localparam logic [REG_W-1:0] G2_MASK = 16'h007f;
   localparam logic [REG_W-1:0] G2_RESET = 16'h0000;

   // ==========================================
   // Stop handshake register fields
   localparam int unsigned HS_USB_REQ = 2;
   localparam int unsigned HS_USB_ACK = 3;
   localparam int unsigned HS_UART_REQ = 4;
   localparam int unsigned HS_UART_ACK = 5;
   localparam logic HS_REQ_RESET = 1'b1;
   localparam logic HS_ACK_RESET = 1'b1;

   // ==========================================
   // Gated clock enables, in output order
   localparam int unsigned N_GATES = 10;
endpackage : pcg_pkg

// file: rtl/pcg_gate_sync.sv
`timescale 1ns/1ps
module pcg_gate_sync #(
   parameter int unsigned W = 10
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [W-1:0] gate_i,
   output logic [W-1:0] clk_en_o
);
   typedef struct packed {
      logic [W-1:0] en;
   } pcg_sync_s;

   pcg_sync_s st_q;
   pcg_sync_s st_d;

   // ==========================================
   // Enables move only on a clock edge, so a gated
   // clock never sees a shortened high or low phase
   always_comb begin
      st_d = st_q;
      st_d.en = ~gate_i;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_q <= '{en: {W{1'b1}}};
      end else begin
         st_q <= st_d;
      end
   end

   assign clk_en_o = st_q.en;
endmodule : pcg_gate_sync

// file: rtl/pcg_top.sv
// Contract
// - Gate one bit 4 stops memory-card 0 clock when 1, runs when 0.
// - Gate one bit 3 stops transfer engine 0 clock when 1.
// - Gate one bit 2 stops asynchronous serial port clock when 1.
// - Gate one bit 1 stops synchronous serial port clock when 1.
// - Gate one bit 0 stops fourth audio port clock when 1.
// - Gate two bit 6 stops clock of analog control registers.
// - Gate two bit 5 stops transfer engine 3 clock when 1.
// - Gate two bit 4 stops transfer engine 2 clock when 1.
// - Gate two bit 3 stops transfer engine 1 clock when 1.
// - Gate two bit 2 stops host link controller clock when 1.
// - Acknowledge set once peripheral agrees and its bus is idle.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module pcg_top (
   input wire logic clock_i,
   input wire logic rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [pcg_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [pcg_pkg::DATA_W-1:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [pcg_pkg::DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Stop handshake with the serial port and host link
   input wire logic uart_stop_ok_i,
   input wire logic uart_busy_i,
   input wire logic usb_stop_ok_i,
   input wire logic usb_busy_i,
   output logic uart_stop_req_o,
   output logic usb_stop_req_o,
   // Clock enables, high while the clock runs
   output logic card_ctrl0_clk_en_o,
   output logic xfer_engine0_clk_en_o,
   output logic async_serial_clk_en_o,
   output logic sync_serial_clk_en_o,
   output logic audio_port3_clk_en_o,
   output logic analog_regs_clk_en_o,
   output logic xfer_engine3_clk_en_o,
   output logic xfer_engine2_clk_en_o,
   output logic xfer_engine1_clk_en_o,
   output logic host_link_clk_en_o
);
   typedef struct packed {
      logic [pcg_pkg::REG_W-1:0] gate_one;
      logic [pcg_pkg::REG_W-1:0] gate_two;
      logic uart_req;
      logic uart_ack;
      logic usb_req;
      logic usb_ack;
      logic [pcg_pkg::DATA_W-1:0] rdata;
   } pcg_state_s;

   pcg_state_s st_q;
   pcg_state_s st_d;

   logic [pcg_pkg::N_GATES-1:0] gate_vec;
   logic [pcg_pkg::N_GATES-1:0] en_vec;
   logic setup_ph;
   logic access_ph;
   logic wr_en;
   logic [pcg_pkg::ADDR_W-1:0] word_idx;
   logic addr_hit;

   // ==========================================
   // Address decoding
   function automatic logic [pcg_pkg::ADDR_W-1:0] to_index(
      input logic [pcg_pkg::ADDR_W-1:0] a
   );
      to_index = a >> pcg_pkg::BYTE_SHIFT;
   endfunction : to_index

   function automatic logic is_mapped(input logic [pcg_pkg::ADDR_W-1:0] a);
      logic [pcg_pkg::ADDR_W-1:0] i;
      i = to_index(a);
      is_mapped = (a[pcg_pkg::BYTE_SHIFT-1:0] == 2'h0) &&
                  ((i == pcg_pkg::IDX_GATE_ONE) ||
                   (i == pcg_pkg::IDX_GATE_TWO) ||
                   (i == pcg_pkg::IDX_STOP_HS));
   endfunction : is_mapped

   // Merges a 16-bit write through the two low byte strobes
   function automatic logic [pcg_pkg::REG_W-1:0] merge16(
      input logic [pcg_pkg::REG_W-1:0] old,
      input logic [pcg_pkg::DATA_W-1:0] wd,
      input logic [3:0] strb
   );
      logic [pcg_pkg::REG_W-1:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = wd[7:0];
      end
      if (strb[1]) begin
         r[15:8] = wd[15:8];
      end
      merge16 = r;
   endfunction : merge16

   assign setup_ph = psel_i && !penable_i;
   assign access_ph = psel_i && penable_i;
   assign word_idx = to_index(paddr_i);
   assign addr_hit = is_mapped(paddr_i);
   assign wr_en = access_ph && pwrite_i && addr_hit;

   // ==========================================
   // Register update and read capture
   always_comb begin
      logic [pcg_pkg::REG_W-1:0] hs_word;
      hs_word = '0;
      st_d = st_q;

      if (wr_en && word_idx == pcg_pkg::IDX_GATE_ONE) begin
         // Reserved bit 5 is stored as written; software keeps it at 1
         st_d.gate_one = merge16(st_q.gate_one, pwdata_i, pstrb_i);
      end

      if (wr_en && word_idx == pcg_pkg::IDX_GATE_TWO) begin
         st_d.gate_two = merge16(st_q.gate_two, pwdata_i, pstrb_i) &
                         pcg_pkg::G2_MASK;
      end

      if (wr_en && word_idx == pcg_pkg::IDX_STOP_HS && pstrb_i[0]) begin
         st_d.uart_req = pwdata_i[pcg_pkg::HS_UART_REQ];
         st_d.usb_req = pwdata_i[pcg_pkg::HS_USB_REQ];
      end

      // acknowledge when idle
      // Follows the request one cycle late; dropping the request
      // withdraws the acknowledge so a stale grant cannot be reused
      st_d.uart_ack = st_q.uart_req && uart_stop_ok_i && !uart_busy_i;
      st_d.usb_ack = st_q.usb_req && usb_stop_ok_i && !usb_busy_i;

      hs_word[pcg_pkg::HS_UART_REQ] = st_q.uart_req;
      hs_word[pcg_pkg::HS_UART_ACK] = st_q.uart_ack;
      hs_word[pcg_pkg::HS_USB_REQ] = st_q.usb_req;
      hs_word[pcg_pkg::HS_USB_ACK] = st_q.usb_ack;

      // Read data is sampled in the setup cycle so it leaves a flop
      if (setup_ph) begin
         st_d.rdata = '0;
         unique case (word_idx)
            pcg_pkg::IDX_GATE_ONE: begin
               st_d.rdata[pcg_pkg::REG_W-1:0] = st_q.gate_one;
            end
            pcg_pkg::IDX_GATE_TWO: begin
               st_d.rdata[pcg_pkg::REG_W-1:0] = st_q.gate_two;
            end
            pcg_pkg::IDX_STOP_HS: begin
               st_d.rdata[pcg_pkg::REG_W-1:0] = hs_word;
            end
            default: begin
               st_d.rdata = '0;
            end
         endcase
         if (!addr_hit) begin
            st_d.rdata = '0;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_q <= '{gate_one: pcg_pkg::G1_RESET,
                   gate_two: pcg_pkg::G2_RESET,
                   uart_req: pcg_pkg::HS_REQ_RESET,
                   uart_ack: pcg_pkg::HS_ACK_RESET,
                   usb_req: pcg_pkg::HS_REQ_RESET,
                   usb_ack: pcg_pkg::HS_ACK_RESET,
                   rdata: '0};
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================
   // Bus answer: zero wait states, error on unmapped words
   assign pready_o = 1'b1;
   assign pslverr_o = access_ph && !addr_hit;
   assign prdata_o = st_q.rdata;
   assign uart_stop_req_o = st_q.uart_req;
   assign usb_stop_req_o = st_q.usb_req;

   // ==========================================
   // Gate bits, 1 stops the clock
   always_comb begin
      gate_vec[0] = st_q.gate_one[pcg_pkg::G1_AUDIO3];
      gate_vec[1] = st_q.gate_one[pcg_pkg::G1_SYNC_SER];
      // asynchronous serial
      // The gate is not interlocked with the acknowledge; software owns it
      gate_vec[2] = st_q.gate_one[pcg_pkg::G1_ASYNC_SER];
      gate_vec[3] = st_q.gate_one[pcg_pkg::G1_XFER0];
      gate_vec[4] = st_q.gate_one[pcg_pkg::G1_CARD0];
      gate_vec[5] = st_q.gate_two[pcg_pkg::G2_HOST_LINK];
      gate_vec[6] = st_q.gate_two[pcg_pkg::G2_XFER1];
      gate_vec[7] = st_q.gate_two[pcg_pkg::G2_XFER2];
      gate_vec[8] = st_q.gate_two[pcg_pkg::G2_XFER3];
      gate_vec[9] = st_q.gate_two[pcg_pkg::G2_ANALOG];
   end

   pcg_gate_sync #(
      .W(pcg_pkg::N_GATES)
   ) u_gate_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .gate_i(gate_vec),
      .clk_en_o(en_vec)
   );

   assign audio_port3_clk_en_o = en_vec[0];
   assign sync_serial_clk_en_o = en_vec[1];
   assign async_serial_clk_en_o = en_vec[2];
   assign xfer_engine0_clk_en_o = en_vec[3];
   assign card_ctrl0_clk_en_o = en_vec[4];
   assign host_link_clk_en_o = en_vec[5];
   assign xfer_engine1_clk_en_o = en_vec[6];
   assign xfer_engine2_clk_en_o = en_vec[7];
   assign xfer_engine3_clk_en_o = en_vec[8];
   assign analog_regs_clk_en_o = en_vec[9];
endmodule : pcg_top

// file: verif/pcg_props.sv
`timescale 1ns/1ps
module pcg_props (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic uart_stop_req_o,
   input wire logic usb_stop_req_o,
   input wire logic card_ctrl0_clk_en_o,
   input wire logic xfer_engine0_clk_en_o,
   input wire logic async_serial_clk_en_o,
   input wire logic sync_serial_clk_en_o,
   input wire logic audio_port3_clk_en_o,
   input wire logic analog_regs_clk_en_o,
   input wire logic xfer_engine3_clk_en_o,
   input wire logic xfer_engine2_clk_en_o,
   input wire logic xfer_engine1_clk_en_o,
   input wire logic host_link_clk_en_o
);
   // ==========================================
   // Decode, byte addresses are four times the index
   wire acc = psel_i && penable_i;
   wire map = paddr_i inside {16'h7040, 16'h700c, 16'h70e8};
   wire w1 = acc && pwrite_i && pstrb_i[0] && paddr_i == 16'h7040;
   wire w2 = acc && pwrite_i && pstrb_i[0] && paddr_i == 16'h700c;
   wire wh = acc && pwrite_i && pstrb_i[0] && paddr_i == 16'h70e8;
   wire [4:0] en1 = {card_ctrl0_clk_en_o, xfer_engine0_clk_en_o,
      async_serial_clk_en_o, sync_serial_clk_en_o, audio_port3_clk_en_o};
   wire [4:0] en2 = {analog_regs_clk_en_o, xfer_engine3_clk_en_o,
      xfer_engine2_clk_en_o, xfer_engine1_clk_en_o, host_link_clk_en_o};
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // ==========================================
   // Assertions
   a_gate_one_bits: assert property (w1 |-> ##2
      en1 == ~$past(pwdata_i[4:0], 2)) else $error("gate one enables");
   a_gate_two_bits: assert property (w2 |-> ##2
      en2 == ~$past(pwdata_i[6:2], 2)) else $error("gate two enables");
   a_enable_cause: assert property ($changed({en1, en2})
      |-> $past(w1 || w2, 2)) else $error("enable changed unasked");
   a_two_upper_zero: assert property (acc && !pwrite_i
      && paddr_i == 16'h700c |-> prdata_o[31:7] == 0) else $error("upper");
   a_stop_req: assert property (wh |=> uart_stop_req_o ==
      $past(pwdata_i[4]) && usb_stop_req_o == $past(pwdata_i[2]))
      else $error("stop request");
   a_ready_high: assert property (acc |-> pready_o)
      else $error("pready low");
   a_err_bad: assert property (acc && !map |-> pslverr_o
      && (pwrite_i || prdata_o == 0)) else $error("unmapped access");
   a_err_good: assert property (acc && map |-> !pslverr_o)
      else $error("error on mapped");
   c_w1: cover property (w1);
   c_wh: cover property (wh);
   c_err: cover property (acc && !map);
endmodule : pcg_props

bind pcg_top pcg_props pcg_props_i (.*);

// file: verif/pcg_top_tb_top.sv
`timescale 1ns/1ps
module pcg_top_tb_top;
   logic clock_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [15:0] paddr_i, g1, g2;
   logic [31:0] pwdata_i, prdata_o, v;
   logic [3:0] pstrb_i;
   logic uart_stop_ok_i, uart_busy_i, usb_stop_ok_i, usb_busy_i;
   logic uart_stop_req_o, usb_stop_req_o, card_ctrl0_clk_en_o;
   logic xfer_engine0_clk_en_o, async_serial_clk_en_o, sync_serial_clk_en_o;
   logic audio_port3_clk_en_o, analog_regs_clk_en_o, xfer_engine3_clk_en_o;
   logic xfer_engine2_clk_en_o, xfer_engine1_clk_en_o, host_link_clk_en_o;
   logic [1:0] rq;
   logic [32:0] e, exp_q[$];
   int mismatches = 0, num_checks = 0, seed = 20438;
   localparam logic [15:0] A1 = 16'h7040;
   localparam logic [15:0] A2 = 16'h700c;
   localparam logic [15:0] AH = 16'h70e8;
   pcg_top pcg_top_i (.*);
   initial begin
      clock_i = 0;
      forever #5 clock_i = ~clock_i;
   end
   // ==========================================
   // Tasks
   task automatic cmp(input logic [32:0] got, input logic [32:0] want);
      num_checks++;
      if (got !== want) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : cmp
   task automatic apb(input logic w, input logic [15:0] a,
         input logic [31:0] d, input logic [3:0] s, input logic [32:0] x);
      exp_q.push_back(x);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      pstrb_i <= s;
      @(posedge clock_i);
      penable_i <= 1;
      // No fixed latency assumed, the watchdog ends a hang
      do @(posedge clock_i); while (pready_o !== 1'b1);
      psel_i <= 0;
      penable_i <= 0;
      @(posedge clock_i);
   endtask : apb
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      apb(1, a, d, 4'hf, 33'h0);
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [31:0] d);
      apb(0, a, 32'h0, 4'hf, {1'b0, d});
   endtask : rd
   task automatic chk();
      @(negedge clock_i);
      cmp({uart_stop_req_o, usb_stop_req_o, card_ctrl0_clk_en_o,
         xfer_engine0_clk_en_o, async_serial_clk_en_o, sync_serial_clk_en_o,
         audio_port3_clk_en_o, analog_regs_clk_en_o, xfer_engine3_clk_en_o,
         xfer_engine2_clk_en_o, xfer_engine1_clk_en_o, host_link_clk_en_o},
         {rq, ~g1[4:0], ~g2[6:2]});
      @(posedge clock_i);
   endtask : chk
   task automatic finish_test();
      if (mismatches == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test
   // ==========================================
   // Bus result monitor
   always @(posedge clock_i) begin
      if (psel_i && penable_i && pready_o === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         if (pwrite_i)
            cmp({32'h0, pslverr_o}, {32'h0, e[32]});
         else
            cmp({pslverr_o, prdata_o}, e);
      end
   end
   initial begin
      #50us;
      mismatches++;
      finish_test();
   end
   // ==========================================
   // Scenarios
   initial begin
      {rst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = 52'h8 << 48;
      pstrb_i = 4'hf;
      {uart_stop_ok_i, uart_busy_i, usb_stop_ok_i, usb_busy_i} = 4'b1010;
      g1 = 0;
      g2 = 0;
      rq = 2'b11;
      repeat (5) @(posedge clock_i);
      rst_i <= 0;
      @(posedge clock_i);
      chk();
      rd(A2, 0);
      rd(A1, 0);
      rd(AH, 32'h3c);
      repeat (6) begin
         g1 = 16'($random(seed)) | 16'h0020;
         wr(A1, {16'h0, g1});
         rd(A1, {16'h0, g1});
         chk();
      end
      // Upper lane alone leaves the gate bits untouched
      apb(1, A1, 32'hffff, 4'b0010, 33'h0);
      g1[15:8] = 8'hff;
      rd(A1, {16'h0, g1});
      repeat (6) begin
         v = $random(seed) | 32'h3;
         wr(A2, v);
         g2 = v[15:0] & 16'h007f;
         rd(A2, {16'h0, g2});
         chk();
      end
      apb(0, 16'h7ffc, 32'h0, 4'hf, {1'b1, 32'h0});
      apb(1, 16'h700d, 32'h3, 4'hf, {1'b1, 32'h0});
      rd(A2, {16'h0, g2});
      // gates open before the requests drop
      g1 = 16'h0020;
      wr(A1, {16'h0, g1});
      wr(A2, 32'h3);
      g2 = 16'h3;
      wr(AH, 32'h0);
      rq = 0;
      rd(AH, 32'h0);
      chk();
      // acknowledge waits for agreement and idle bus
      uart_busy_i <= 1;
      usb_busy_i <= 1;
      wr(AH, 32'h14);
      rq = 2'b11;
      rd(AH, 32'h14);
      uart_busy_i <= 0;
      usb_busy_i <= 0;
      usb_stop_ok_i <= 0;
      @(posedge clock_i);
      rd(AH, 32'h34);
      usb_stop_ok_i <= 1;
      uart_stop_ok_i <= 0;
      @(posedge clock_i);
      rd(AH, 32'h1c);
      uart_stop_ok_i <= 1;
      @(posedge clock_i);
      rd(AH, 32'h3c);
      g1 = 16'h0024;
      g2 = 16'h0007;
      wr(A1, {16'h0, g1});
      wr(A2, {16'h0, g2});
      chk();
      // restart clears gates first, then requests
      g1 = 16'h0020;
      g2 = 16'h0003;
      wr(A1, {16'h0, g1});
      wr(A2, {16'h0, g2});
      wr(AH, 32'h0);
      rq = 0;
      chk();
      finish_test();
   end
endmodule : pcg_top_tb_top
